// *** core/iox_slave.sv ***
// serial slave front end of a 16-bit i/o expander with change interrupt
`timescale 1ns/10ps
module iox_slave #(
  parameter int FIFO_DEPTH = iox_pkg::FIFO_D
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic addr_sel_0,
  input wire logic addr_sel_1,
  input wire logic addr_sel_2,
  input wire logic [7:0] port0_pin_i,
  output logic [7:0] port0_pin_o,
  output logic [7:0] port0_pin_oe_n_o,
  input wire logic [7:0] port1_pin_i,
  output logic [7:0] port1_pin_o,
  output logic [7:0] port1_pin_oe_n_o,
  output logic chg_int_o,
  output logic chg_int_oe_n_o,
  input wire logic upd_hold_i
);
  localparam int PW = iox_pkg::PW;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [2*PW+4:0] sync_w;
  iox_sync #(.W(2*PW+5)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i({scl_i, sda_i, addr_sel_2, addr_sel_1, addr_sel_0, port1_pin_i, port0_pin_i}),
    .sync_o(sync_w)
  );
  wire scl_s = sync_w[2*PW+4];
  wire sda_s = sync_w[2*PW+3];
  wire [2:0] asel_s = sync_w[2*PW+2:2*PW];
  logic [PW-1:0] pin_s [iox_pkg::NPORT];
  assign pin_s[0] = sync_w[PW-1:0];
  assign pin_s[1] = sync_w[2*PW-1:PW];

  ////////////////////////////////////////////////////////////////////////////
  // bus condition detection
  logic scl_q_ff;
  logic sda_q_ff;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end
  wire scl_rise = scl_s && !scl_q_ff;
  wire scl_fall = !scl_s && scl_q_ff;
  // data moving under a high clock is a condition, never a data bit
  wire start_det = scl_s && scl_q_ff && sda_q_ff && !sda_s;
  wire stop_det = scl_s && scl_q_ff && !sda_q_ff && sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [PW-1:0] out_ff [iox_pkg::NPORT];
  logic [PW-1:0] pol_ff [iox_pkg::NPORT];
  logic [PW-1:0] cfg_ff [iox_pkg::NPORT];
  logic [PW-1:0] in_ff [iox_pkg::NPORT];
  logic init_ff;

  iox_strm_if #(.W(iox_pkg::FIFO_W)) push_if ();
  iox_strm_if #(.W(iox_pkg::FIFO_W)) drain_if ();

  // writes queue up so a held register update never stalls the bus
  iox_fifo #(.W(iox_pkg::FIFO_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .wr(push_if),
    .rd(drain_if)
  );

  assign drain_if.ready = !upd_hold_i;
  wire drain_go = drain_if.valid && drain_if.ready;
  wire [2:0] wr_reg = drain_if.data[PW+2:PW];
  wire [PW-1:0] wr_val = drain_if.data[PW-1:0];

  // read value of a register; input ports read through polarity inversion
  function automatic logic [PW-1:0] reg_rd(input logic [2:0] r,
                                           input logic [PW-1:0] in0,
                                           input logic [PW-1:0] in1,
                                           input logic [PW-1:0] o0,
                                           input logic [PW-1:0] o1,
                                           input logic [PW-1:0] p0,
                                           input logic [PW-1:0] p1,
                                           input logic [PW-1:0] c0,
                                           input logic [PW-1:0] c1);
    logic [PW-1:0] v;
    v = '0;
    case (r)
      iox_pkg::REG_IN0: v = in0 ^ p0;
      iox_pkg::REG_IN1: v = in1 ^ p1;
      iox_pkg::REG_OUT0: v = o0;
      iox_pkg::REG_OUT1: v = o1;
      iox_pkg::REG_POL0: v = p0;
      iox_pkg::REG_POL1: v = p1;
      iox_pkg::REG_CFG0: v = c0;
      iox_pkg::REG_CFG1: v = c1;
      default: v = '0;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // byte engine
  iox_pkg::iox_state_t st_ff;
  iox_pkg::iox_state_t nxt_st;
  logic [3:0] bit_ff;
  logic [PW-1:0] sh_ff;
  logic [PW-1:0] tx_ff;
  logic [2:0] ptr_ff;
  logic ack_ff;
  logic rw_ff;
  logic sda_oe_n_ff;

  wire byte_done = scl_fall && (bit_ff == iox_pkg::BYTE_BITS);
  wire addr_hit = (sh_ff[7:1] == {iox_pkg::ADDR_FIXED, asel_s});
  wire [2:0] ptr_pair = {ptr_ff[2:1], ~ptr_ff[0]};
  wire push_go = (st_ff == iox_pkg::IOX_WDATA) && byte_done;
  wire load_first = (st_ff == iox_pkg::IOX_ADDR_ACK) && scl_fall && rw_ff;
  wire load_next = (st_ff == iox_pkg::IOX_RDATA_ACK) && scl_fall && ack_ff;
  wire load_tx = load_first || load_next;
  // capture a port only when that port itself is loaded for reading
  wire cap0 = load_tx && (ptr_ff == iox_pkg::REG_IN0);
  wire cap1 = load_tx && (ptr_ff == iox_pkg::REG_IN1);
  wire [PW-1:0] rd_val = reg_rd(ptr_ff, pin_s[0], pin_s[1], out_ff[0], out_ff[1],
                                pol_ff[0], pol_ff[1], cfg_ff[0], cfg_ff[1]);

  assign push_if.valid = push_go;
  assign push_if.data = {ptr_ff, sh_ff};

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      iox_pkg::IOX_IDLE: nxt_st = iox_pkg::IOX_IDLE;
      iox_pkg::IOX_ADDR: begin
        if (byte_done) begin
          nxt_st = addr_hit ? iox_pkg::IOX_ADDR_ACK : iox_pkg::IOX_IDLE;
        end
      end
      iox_pkg::IOX_ADDR_ACK: begin
        if (scl_fall) begin
          nxt_st = rw_ff ? iox_pkg::IOX_RDATA : iox_pkg::IOX_CMD;
        end
      end
      iox_pkg::IOX_CMD: begin
        if (byte_done) begin
          nxt_st = iox_pkg::IOX_CMD_ACK;
        end
      end
      iox_pkg::IOX_CMD_ACK: begin
        if (scl_fall) begin
          nxt_st = iox_pkg::IOX_WDATA;
        end
      end
      iox_pkg::IOX_WDATA: begin
        if (byte_done) begin
          nxt_st = iox_pkg::IOX_WDATA_ACK;
        end
      end
      iox_pkg::IOX_WDATA_ACK: begin
        if (scl_fall) begin
          nxt_st = iox_pkg::IOX_WDATA;
        end
      end
      iox_pkg::IOX_RDATA: begin
        if (scl_fall && bit_ff[2:0] == iox_pkg::BIT_LAST) begin
          nxt_st = iox_pkg::IOX_RDATA_ACK;
        end
      end
      iox_pkg::IOX_RDATA_ACK: begin
        if (scl_fall) begin
          nxt_st = ack_ff ? iox_pkg::IOX_RDATA : iox_pkg::IOX_IDLE;
        end
      end
      default: nxt_st = iox_pkg::IOX_IDLE;
    endcase
    if (start_det) begin
      nxt_st = iox_pkg::IOX_ADDR;
    end
    if (stop_det) begin
      nxt_st = iox_pkg::IOX_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_ff <= iox_pkg::IOX_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  wire rx_st = (st_ff == iox_pkg::IOX_ADDR) || (st_ff == iox_pkg::IOX_CMD) ||
               (st_ff == iox_pkg::IOX_WDATA);
  wire [3:0] nxt_bit = (start_det || byte_done || load_tx) ? 4'h0 :
                       ((rx_st && scl_rise) || (st_ff == iox_pkg::IOX_RDATA && scl_fall)) ?
                       bit_ff + 4'h1 : bit_ff;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      rw_ff <= 1'b0;
    end else begin
      bit_ff <= nxt_bit;
      if (rx_st && scl_rise) begin
        sh_ff <= {sh_ff[PW-2:0], sda_s};
      end
      if (st_ff == iox_pkg::IOX_ADDR && byte_done) begin
        rw_ff <= sh_ff[0];
      end
    end
  end

  // pointer survives stop and start, so a bare read resumes from it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ptr_ff <= iox_pkg::REG_IN0;
    end else if (st_ff == iox_pkg::IOX_CMD && byte_done) begin
      ptr_ff <= sh_ff[2:0];
    end else if ((push_go && push_if.ready) || load_tx) begin
      ptr_ff <= ptr_pair;
    end
  end

  // a full fifo answers with not-acknowledge instead of losing the byte
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else if (st_ff == iox_pkg::IOX_ADDR && byte_done) begin
      ack_ff <= addr_hit;
    end else if (st_ff == iox_pkg::IOX_CMD && byte_done) begin
      ack_ff <= 1'b1;
    end else if (push_go) begin
      ack_ff <= push_if.ready;
    end else if (st_ff == iox_pkg::IOX_RDATA_ACK && scl_rise) begin
      ack_ff <= !sda_s;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_ff <= 8'hFF;
    end else if (load_tx) begin
      tx_ff <= rd_val;
    end else if (st_ff == iox_pkg::IOX_RDATA && scl_fall) begin
      tx_ff <= {tx_ff[PW-2:0], 1'b1};
    end
  end

  wire ack_st = (st_ff == iox_pkg::IOX_ADDR_ACK) || (st_ff == iox_pkg::IOX_CMD_ACK) ||
                (st_ff == iox_pkg::IOX_WDATA_ACK);
  wire drive_low = (ack_st && ack_ff) ||
                   (st_ff == iox_pkg::IOX_RDATA && !tx_ff[PW-1]);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sda_oe_n_ff <= 1'b1;
    end else begin
      sda_oe_n_ff <= !drive_low;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n_o = sda_oe_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // registers per port and change detection
  logic [iox_pkg::NPORT-1:0] chg_w;

  // capture waits until the pin synchronisers hold real levels, not their reset ones
  logic [1:0] init_sh_ff;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      init_sh_ff <= '1;
      init_ff <= 1'b1;
    end else begin
      init_sh_ff <= {init_sh_ff[0], 1'b0};
      init_ff <= init_sh_ff[1];
    end
  end

  generate
    for (genvar p = 0; p < iox_pkg::NPORT; p++) begin : g_port
      wire wr_me = drain_go && (wr_reg[0] == 1'(p));
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          out_ff[p] <= iox_pkg::RST_OUT;
          pol_ff[p] <= iox_pkg::RST_POL;
          cfg_ff[p] <= iox_pkg::RST_CFG;
        end else if (wr_me) begin
          // input port targets fall through unchanged
          case (wr_reg[2:1])
            iox_pkg::REG_OUT0[2:1]: out_ff[p] <= wr_val;
            iox_pkg::REG_POL0[2:1]: pol_ff[p] <= wr_val;
            iox_pkg::REG_CFG0[2:1]: cfg_ff[p] <= wr_val;
            default: out_ff[p] <= out_ff[p];
          endcase
        end
      end
      // first capture after reset avoids a request on idle pins
      wire cap_me = init_ff || (p == 0 ? cap0 : cap1);
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          in_ff[p] <= 8'h00;
        end else if (cap_me) begin
          in_ff[p] <= pin_s[p];
        end
      end
      // only input-configured bits compare; output bits are masked off
      assign chg_w[p] = !init_ff && |((pin_s[p] ^ in_ff[p]) & cfg_ff[p]);
    end
  endgenerate

  logic chg_int_ff;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      chg_int_ff <= 1'b0;
    end else begin
      chg_int_ff <= |chg_w;
    end
  end

  assign chg_int_o = 1'b0;
  assign chg_int_oe_n_o = !chg_int_ff;
  assign port0_pin_o = out_ff[0];
  assign port1_pin_o = out_ff[1];
  assign port0_pin_oe_n_o = cfg_ff[0];
  assign port1_pin_oe_n_o = cfg_ff[1];
endmodule

// *** inc/iox_pkg.sv ***
// shared constants and types of the i/o expander serial slave
package iox_pkg;
  localparam int NPORT = 2;
  localparam int PW = 8;
  localparam logic [3:0] ADDR_FIXED = 4'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] REG_IN0 = 3'h0;
  localparam logic [2:0] REG_IN1 = 3'h1;
  localparam logic [2:0] REG_OUT0 = 3'h2;
  localparam logic [2:0] REG_OUT1 = 3'h3;
  localparam logic [2:0] REG_POL0 = 3'h4;
  localparam logic [2:0] REG_POL1 = 3'h5;
  localparam logic [2:0] REG_CFG0 = 3'h6;
  localparam logic [2:0] REG_CFG1 = 3'h7;
  localparam logic [7:0] RST_OUT = 8'hFF;
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [7:0] RST_CFG = 8'hFF;
  localparam int FIFO_W = 11;
  localparam int FIFO_D = 16;
  typedef enum logic [3:0] {
    IOX_IDLE, IOX_ADDR, IOX_ADDR_ACK, IOX_CMD, IOX_CMD_ACK,
    IOX_WDATA, IOX_WDATA_ACK, IOX_RDATA, IOX_RDATA_ACK
  } iox_state_t;
endpackage

// *** inc/iox_strm_if.sv ***
// valid/ready word stream between the slave and its write fifo
`timescale 1ns/10ps
interface iox_strm_if #(parameter int W = 11);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** core/iox_sync.sv ***
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module iox_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // reset level high matches an idle bus and pulled-up pins
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule

// *** core/iox_fifo.sv ***
// parameterised valid/ready fifo
`timescale 1ns/10ps
module iox_fifo #(
  parameter int W = 11,
  parameter int D = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  iox_strm_if.snk wr,
  iox_strm_if.src rd
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp_ff;
  logic [AW:0] rp_ff;
  wire full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  wire empty = (wp_ff == rp_ff);
  wire do_wr = wr.valid && !full;
  wire do_rd = rd.ready && !empty;

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rp_ff[AW-1:0]];

  always_ff @(posedge clk_sys_i) begin
    if (do_wr) begin
      mem[wp_ff[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      wp_ff <= wp_ff + (AW+1)'(do_wr);
      rp_ff <= rp_ff + (AW+1)'(do_rd);
    end
  end
endmodule

// *** tb/iox_slave_asserts.sv ***
// concurrent checks on the ports of the i/o expander serial slave
`timescale 1ns/10ps
module iox_slave_asserts #(
  parameter int FIFO_DEPTH = iox_pkg::FIFO_D
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic [7:0] port0_pin_i,
  input wire logic [7:0] port0_pin_o,
  input wire logic [7:0] port0_pin_oe_n_o,
  input wire logic [7:0] port1_pin_i,
  input wire logic [7:0] port1_pin_o,
  input wire logic [7:0] port1_pin_oe_n_o,
  input wire logic chg_int_o,
  input wire logic chg_int_oe_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [15:0] in_mask, mask_ff, cfg_ff;
  logic [3:0] quiet_ff, nxt_quiet;
  ////////////////////////////////////////////////////////////////
  // cycles since an input-configured pin or a direction bit moved; output pins are masked out
  assign in_mask = {port1_pin_i & port1_pin_oe_n_o, port0_pin_i & port0_pin_oe_n_o};
  assign nxt_quiet = (rst_i || in_mask != mask_ff
    || {port1_pin_oe_n_o, port0_pin_oe_n_o} != cfg_ff) ? 4'h0
    : quiet_ff + {3'h0, quiet_ff != 4'hF};
  always_ff @(posedge clk_sys_i) begin
    mask_ff <= in_mask;
    cfg_ff <= {port1_pin_oe_n_o, port0_pin_oe_n_o};
    quiet_ff <= nxt_quiet;
  end
  ////////////////////////////////////////////////////////////////
  a_rst_values: assert property (
    $fell(rst_i) |-> sda_oe_n_o && chg_int_oe_n_o && (port0_pin_o & port1_pin_o) == 8'hFF
      && (port0_pin_oe_n_o & port1_pin_oe_n_o) == 8'hFF)
    else $error("outputs not at reset values");
  a_sda_zero: assert property (sda_o == 1'b0)
    else $error("data pin value not low");
  a_int_zero: assert property (chg_int_o == 1'b0)
    else $error("interrupt pin value not low");
  a_sda_low_move: assert property (
    $changed(sda_oe_n_o) |-> !$past(scl_i, 2))
    else $error("data line moved while clock high");
  a_ack_holds_high: assert property (
    $rose(scl_i) && !sda_oe_n_o |=> !sda_oe_n_o [*3])
    else $error("pull dropped during clock high");
  a_stop_releases: assert property (
    scl_i && $past(scl_i) && $rose(sda_i) |=> sda_oe_n_o [*8])
    else $error("data line pulled after stop");
  a_int_prompt: assert property (
    chg_int_oe_n_o && $stable({port1_pin_oe_n_o, port0_pin_oe_n_o}) && $changed(in_mask)
      |-> ##[1:8] !chg_int_oe_n_o)
    else $error("input change raised no interrupt");
  a_int_cause: assert property (
    $fell(chg_int_oe_n_o) |-> quiet_ff < 4'h8)
    else $error("interrupt without input change");
endmodule

bind iox_slave iox_slave_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.clk_sys_i, .rst_i, .scl_i,
  .sda_i, .sda_o, .sda_oe_n_o, .port0_pin_i, .port0_pin_o, .port0_pin_oe_n_o, .port1_pin_i,
  .port1_pin_o, .port1_pin_oe_n_o, .chg_int_o, .chg_int_oe_n_o);

// *** tb/iox_bus_master.sv ***
// behavioural two-wire bus master facing the slave
`timescale 1ns/10ps
module iox_bus_master (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_n_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  // a quarter of the 320 ns bit; every move lands on a falling clk edge
  task automatic qtr();
    repeat (2) @(negedge clk_i);
  endtask
  // also a repeated start: clock stays low until the slave has let go of its ack
  task automatic start();
    sda_oe_n_o = 1'b1;
    repeat (3) qtr();
    scl_o = 1'b1;
    qtr();
    sda_oe_n_o = 1'b0;
    qtr();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    qtr();
    sda_oe_n_o = 1'b0;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_oe_n_o = 1'b1;
    qtr();
  endtask
  // data set mid-low, sampled mid-high, well clear of the slave's answer delay
  task automatic bit_x(input logic b, output logic r);
    qtr();
    sda_oe_n_o = b;
    qtr();
    scl_o = 1'b1;
    qtr();
    r = sda_i;
    qtr();
    scl_o = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule

// *** tb/iox_slave_tb_top.sv ***
// self-checking bench for the i/o expander serial slave
`timescale 1ns/10ps
module iox_slave_tb_top;
  logic clk_sys_i, rst_i, upd_hold_i;
  logic [2:0] asel;
  logic [7:0] ext0, ext1, p0_i, p0_o, p0_oe_n, p1_i, p1_o, p1_oe_n;
  logic scl, sda, m_sda_oe_n, d_sda, d_sda_oe_n, int_v, int_oe_n;
  logic [7:0] bq[$];
  int n_errors = 0;
  int checks_done = 0;
  ////////////////////////////////////////////////////////////////
  // pull-ups on the bus; a pin configured as output shows its driver
  assign sda = m_sda_oe_n & (d_sda_oe_n | d_sda);
  assign p0_i = (p0_o & ~p0_oe_n) | (ext0 & p0_oe_n);
  assign p1_i = (p1_o & ~p1_oe_n) | (ext1 & p1_oe_n);
  iox_slave dut_u (.clk_sys_i, .rst_i, .scl_i(scl), .sda_i(sda), .sda_o(d_sda),
    .sda_oe_n_o(d_sda_oe_n), .addr_sel_0(asel[0]), .addr_sel_1(asel[1]),
    .addr_sel_2(asel[2]), .port0_pin_i(p0_i), .port0_pin_o(p0_o),
    .port0_pin_oe_n_o(p0_oe_n), .port1_pin_i(p1_i), .port1_pin_o(p1_o),
    .port1_pin_oe_n_o(p1_oe_n), .chg_int_o(int_v), .chg_int_oe_n_o(int_oe_n), .upd_hold_i);
  iox_bus_master m_u (.clk_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_sda_oe_n));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] dq[$], input int n_ok);
    logic ack;
    m_u.start();
    m_u.put_byte({iox_pkg::ADDR_FIXED, asel, 1'b0}, ack);
    chk8({7'h0, ack}, 8'h01);
    m_u.put_byte(cmd, ack);
    chk8({7'h0, ack}, 8'h01);
    foreach (dq[i]) begin
      m_u.put_byte(dq[i], ack);
      chk8({7'h0, ack}, {7'h0, i < n_ok});
    end
    m_u.stop();
    wt(8);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic with_cmd, input logic [7:0] eq[$]);
    logic ack;
    logic [7:0] d;
    if (with_cmd) begin
      m_u.start();
      m_u.put_byte({iox_pkg::ADDR_FIXED, asel, 1'b0}, ack);
      m_u.put_byte(cmd, ack);
    end
    m_u.start();
    m_u.put_byte({iox_pkg::ADDR_FIXED, asel, 1'b1}, ack);
    chk8({7'h0, ack}, 8'h01);
    foreach (eq[i]) begin
      m_u.get_byte(i == eq.size() - 1, d);
      chk8(d, eq[i]);
    end
    m_u.stop();
    wt(8);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic ack;
    rst_i = 1'b1;
    upd_hold_i = 1'b0;
    asel = 3'h5;
    ext0 = 8'hF0;
    ext1 = 8'h5A;
    wt(16);
    rst_i = 1'b0;
    wt(8);
    chk8(p0_oe_n & p1_oe_n, iox_pkg::RST_CFG);
    chk8(p0_o & p1_o, iox_pkg::RST_OUT);
    chk8({7'h0, int_oe_n}, 8'h01);
    for (int c = 2; c < 8; c += 2) begin
      v = (c == 4) ? iox_pkg::RST_POL : ((c == 2) ? iox_pkg::RST_OUT : iox_pkg::RST_CFG);
      rd(8'(c + 1), 1'b1, '{v, v});
    end
    m_u.start();
    m_u.put_byte({iox_pkg::ADDR_FIXED, ~asel, 1'b0}, ack);
    chk8({7'h0, ack}, 8'h00);
    m_u.stop();
    $display("test reset_and_address done");
    wr(8'h03, '{8'hA5, 8'h3C, 8'h81}, 3);
    chk8(p1_o, 8'h81);
    chk8(p0_o, 8'h3C);
    wr(8'h06, '{8'h0F, 8'h7F}, 2);
    chk8(p0_oe_n, 8'h0F);
    chk8(p1_oe_n, 8'h7F);
    wr(8'h04, '{8'h01}, 1);
    wr(8'h00, '{8'h00, 8'h00}, 2);
    rd(8'h01, 1'b1, '{8'hDA, 8'h31});
    chk8({7'h0, int_oe_n}, 8'h01);
    $display("test registers done");
    ext0 = 8'hF1;
    wt(10);
    chk8({7'h0, int_oe_n}, 8'h00);
    ext0 = 8'hF0;
    wt(10);
    chk8({7'h0, int_oe_n}, 8'h01);
    wr(8'h02, '{8'hC3}, 1);
    chk8({7'h0, int_oe_n}, 8'h01);
    ext1 = 8'h5B;
    wt(10);
    chk8({7'h0, int_oe_n}, 8'h00);
    rd(8'h00, 1'b1, '{8'hC1});
    chk8({7'h0, int_oe_n}, 8'h00);
    rd(8'h00, 1'b0, '{8'hDB});
    chk8({7'h0, int_oe_n}, 8'h01);
    $display("test interrupt done");
    // updates held so the write buffer fills and the seventeenth byte is refused
    upd_hold_i = 1'b1;
    for (int i = 0; i < 17; i++) bq.push_back(8'h10 + 8'(i));
    wr(8'h02, bq, 16);
    chk8(p0_o, 8'hC3);
    upd_hold_i = 1'b0;
    wt(64);
    chk8(p0_o, 8'h1E);
    chk8(p1_o, 8'h1F);
    $display("test buffer done");
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    n_errors++;
    $display("[FAIL] t=%0t hang got=%h exp=%h", $time, 8'h0, 8'h1);
    print_verdict();
  end
endmodule
